// *** src/cor_consts.vh ***
// Constants for the clock output and PLL pin override register group
`ifndef COR_CONSTS_VH
`define COR_CONSTS_VH

// Register addresses on the serial port
`define COR_ADDR_W          15
`define COR_ADDR_PRE_EMPH   15'h0048
`define COR_ADDR_TRIG_CTRL  15'h0057
`define COR_ADDR_PLL_OVR    15'h0058

// Reset values
`define COR_RST_PRE_EMPH    8'h00
`define COR_RST_TRIG_CTRL   8'h00
`define COR_RST_PLL_OVR     8'h00

// Serial frame: one read/write bit, address, one data byte
`define COR_SPI_HDR_BITS    5'h10
`define COR_SPI_LAST_BIT    5'h17
`define COR_SPI_DONE_BITS   5'h18

// Field positions
`define COR_PE_MSB          3
`define COR_PE_LSB          0
`define COR_TRIG_EN_BIT     7
`define COR_TRIG_MODE_MSB   2
`define COR_TRIG_MODE_LSB   0
`define COR_OVR_EN_BIT      7
`define COR_SECOND_MSB      5
`define COR_SECOND_LSB      4
`define COR_FIRST_MSB       3
`define COR_FIRST_LSB       2
`define COR_SE_SEL_BIT      1
`define COR_PLL_EN_BIT      0

// Lanes sharing the pre-emphasis setting
`define COR_LANES           8
`define COR_PE_W            4

// Trigger output modes
`define COR_TRIG_UI16       3'h0
`define COR_TRIG_UI32       3'h1
`define COR_TRIG_UI64       3'h2
`define COR_TRIG_TSTAMP     3'h3

// Half periods in serializer unit-interval ticks
`define COR_HALF_UI16       6'h08
`define COR_HALF_UI32       6'h10
`define COR_HALF_UI64       6'h20

// Reference output modes and half periods in reference half-cycle ticks
`define COR_REF_OFF         2'h0
`define COR_REF_DIV1        2'h1
`define COR_REF_DIV2        2'h2
`define COR_REF_DIV4        2'h3
`define COR_HALF_DIV1       6'h01
`define COR_HALF_DIV2       6'h02
`define COR_HALF_DIV4       6'h04
`define COR_HALF_NONE       6'h00

`endif

// *** src/cor_clk_div.v ***
// Tick-driven clock divider with an even duty cycle
`timescale 1ns/1ns
`include "cor_consts.vh"

module cor_clk_div (
   clk,
   sys_rst,
   en,
   tick,
   half_count,
   clk_out_q
);
   input  wire       clk;
   input  wire       sys_rst;
   input  wire       en;
   input  wire       tick;
   input  wire [5:0] half_count;
   output reg        clk_out_q;

   reg [5:0] cnt_q;

   // Disable parks the output low so it restarts from a known phase
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q     <= 6'h00;
         clk_out_q <= 1'b0;
      end else if (!en || half_count == `COR_HALF_NONE) begin
         cnt_q     <= 6'h00;
         clk_out_q <= 1'b0;
      end else if (tick) begin
         if (cnt_q >= half_count - 6'h01) begin
            cnt_q     <= 6'h00;
            clk_out_q <= ~clk_out_q;
         end else begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end
endmodule // cor_clk_div

// *** src/cor_regs.v ***
// Clock output and PLL pin override registers behind the serial port
`timescale 1ns/1ns
`include "cor_consts.vh"

// How it works
// - One four-bit pre-emphasis value drives all serializer lanes together.
// - Trigger enable bit gates the trigger output buffer and divider.
// - Mode 0/1/2 give 16/32/64 UI clocks, 3 the timestamp, rest reserved.
// - All three registers reset to zero: trigger off, pins in control.
// - Override enable picks register fields over the PLL configuration pins.
// - Under override, bits 5:4 set second reference output off, /1, /2, /4.
// - Without override, second output mode field is ignored; pins decide.
// - Second reference output runs only while the first one runs.
// - Under override, bits 3:2 set first reference output; else pins.
// - Under override, bit 1 selects the single-ended reference input.
// - Under override, bit 0 enables the sampling PLL.
module cor_regs (
   clk,
   sys_rst,
   spi_sclk,
   spi_sdi,
   spi_sen_n,
   spi_sdo_q,
   spi_sdo_oe_n_q,
   ser_ui_tick,
   ser_reinit,
   ref_half_tick,
   timestamp_input,
   clock_config_pin_a,
   clock_config_pin_b,
   single_ended_ref_pin,
   pll_enable_pin,
   lane_pre_emphasis_q,
   pulse_output_pin_q,
   first_ref_output_q,
   second_ref_output_q,
   single_ended_ref_sel_q,
   pll_enable_q
);
   input  wire        clk;
   input  wire        sys_rst;
   input  wire        spi_sclk;
   input  wire        spi_sdi;
   input  wire        spi_sen_n;
   output reg         spi_sdo_q;
   output reg         spi_sdo_oe_n_q;
   input  wire        ser_ui_tick;
   input  wire        ser_reinit;
   input  wire        ref_half_tick;
   input  wire        timestamp_input;
   input  wire        clock_config_pin_a;
   input  wire        clock_config_pin_b;
   input  wire        single_ended_ref_pin;
   input  wire        pll_enable_pin;
   output reg  [31:0] lane_pre_emphasis_q;
   output reg         pulse_output_pin_q;
   output reg         first_ref_output_q;
   output reg         second_ref_output_q;
   output reg         single_ended_ref_sel_q;
   output reg         pll_enable_q;

   // Reference output mode to half period in ticks
   function [5:0] ref_half;
      input [1:0] mode;
      begin
         case (mode)
            `COR_REF_DIV1: ref_half = `COR_HALF_DIV1;
            `COR_REF_DIV2: ref_half = `COR_HALF_DIV2;
            `COR_REF_DIV4: ref_half = `COR_HALF_DIV4;
            default:       ref_half = `COR_HALF_NONE;
         endcase
      end
   endfunction

   // Configuration pin pair to a reference output mode
   function [1:0] pin_mode;
      input       second;
      input [1:0] pins;
      begin
         case (pins)
            2'h1:    pin_mode = second ? `COR_REF_OFF : `COR_REF_DIV1;
            2'h2:    pin_mode = `COR_REF_DIV1;
            2'h3:    pin_mode = `COR_REF_DIV2;
            default: pin_mode = `COR_REF_OFF;
         endcase
      end
   endfunction

   reg  [7:0]             pre_emph_q;
   reg  [7:0]             trig_ctrl_q;
   reg  [7:0]             pll_ovr_q;
   reg                    sclk_q;
   reg  [4:0]             bit_cnt_q;
   reg  [22:0]            shift_q;
   reg                    rd_q;
   reg  [`COR_ADDR_W-1:0] addr_q;
   reg  [7:0]             rd_sh_q;
   reg                    ts_q;
   reg  [7:0]             rdata;
   wire                   sclk_rise;
   wire                   sclk_fall;
   wire [7:0]             wdata;
   wire                   wr_stb;
   wire                   trig_en;
   wire [2:0]             trig_mode;
   wire                   ovr_en;
   wire [1:0]             pins;
   wire [1:0]             first_mode;
   wire [1:0]             second_mode;
   wire [1:0]             second_eff;
   reg  [5:0]             trig_half;
   wire                   trig_div_en;
   wire                   trig_div_out;
   wire                   first_div_out;
   wire                   second_div_out;
   wire [31:0]            lane_pre_emphasis_d;

   // Serial port; host keeps sclk well below clk/4 so each level is seen
   assign sclk_rise = spi_sclk & ~sclk_q;
   assign sclk_fall = ~spi_sclk & sclk_q;
   assign wdata     = {shift_q[6:0], spi_sdi};
   assign wr_stb    = sclk_rise & ~spi_sen_n & ~rd_q & (bit_cnt_q == `COR_SPI_LAST_BIT);

   always @* begin
      case (addr_q)
         `COR_ADDR_PRE_EMPH:  rdata = pre_emph_q;
         `COR_ADDR_TRIG_CTRL: rdata = trig_ctrl_q;
         `COR_ADDR_PLL_OVR:   rdata = pll_ovr_q;
         default:             rdata = 8'h00;
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_q         <= 1'b0;
         bit_cnt_q      <= 5'h00;
         shift_q        <= 23'h000000;
         rd_q           <= 1'b0;
         addr_q         <= {`COR_ADDR_W{1'b0}};
         rd_sh_q        <= 8'h00;
         spi_sdo_q      <= 1'b0;
         spi_sdo_oe_n_q <= 1'b1;
      end else begin
         sclk_q <= spi_sclk;
         if (spi_sen_n) begin
            bit_cnt_q      <= 5'h00;
            rd_q           <= 1'b0;
            spi_sdo_oe_n_q <= 1'b1;
         end else begin
            if (sclk_rise && bit_cnt_q != `COR_SPI_DONE_BITS) begin
               shift_q   <= {shift_q[21:0], spi_sdi};
               bit_cnt_q <= bit_cnt_q + 5'h01;
               if (bit_cnt_q == `COR_SPI_HDR_BITS - 5'h01) begin
                  rd_q   <= shift_q[14];
                  addr_q <= {shift_q[13:0], spi_sdi};
               end
            end
            // Read data loaded once the header is in
            if (bit_cnt_q == `COR_SPI_HDR_BITS && sclk_q && rd_q && spi_sdo_oe_n_q) begin
               rd_sh_q <= rdata;
            end
            if (sclk_fall && rd_q && bit_cnt_q >= `COR_SPI_HDR_BITS
                && bit_cnt_q != `COR_SPI_DONE_BITS) begin
               spi_sdo_q      <= rd_sh_q[7];
               rd_sh_q        <= {rd_sh_q[6:0], 1'b0};
               spi_sdo_oe_n_q <= 1'b0;
            end
         end
      end
   end

   // Reserved bits stored as written; software keeps them zero
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_emph_q  <= `COR_RST_PRE_EMPH;
         trig_ctrl_q <= `COR_RST_TRIG_CTRL;
         pll_ovr_q   <= `COR_RST_PLL_OVR;
      end else if (wr_stb) begin
         case (addr_q)
            `COR_ADDR_PRE_EMPH:  pre_emph_q  <= wdata;
            `COR_ADDR_TRIG_CTRL: trig_ctrl_q <= wdata;
            `COR_ADDR_PLL_OVR:   pll_ovr_q   <= wdata;
            default:             pre_emph_q  <= pre_emph_q;
         endcase
      end
   end

   // One setting fanned out to every lane
   genvar lane;
   generate
      for (lane = 0; lane < `COR_LANES; lane = lane + 1) begin : g_lane
         assign lane_pre_emphasis_d[lane*`COR_PE_W +: `COR_PE_W] =
            pre_emph_q[`COR_PE_MSB:`COR_PE_LSB];
      end
   endgenerate

   // One process for the whole bus keeps a single driver on the output
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lane_pre_emphasis_q <= 32'h00000000;
      end else begin
         lane_pre_emphasis_q <= lane_pre_emphasis_d;
      end
   end

   // Trigger output
   assign trig_en   = trig_ctrl_q[`COR_TRIG_EN_BIT];
   assign trig_mode = trig_ctrl_q[`COR_TRIG_MODE_MSB:`COR_TRIG_MODE_LSB];

   always @* begin
      case (trig_mode)
         `COR_TRIG_UI16: trig_half = `COR_HALF_UI16;
         `COR_TRIG_UI32: trig_half = `COR_HALF_UI32;
         `COR_TRIG_UI64: trig_half = `COR_HALF_UI64;
         default:        trig_half = `COR_HALF_NONE;
      endcase
   end

   // Serializer restart resets divider phase, so the clock drops briefly
   assign trig_div_en = trig_en & ~ser_reinit;

   cor_clk_div u_trig_div (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .en         (trig_div_en),
      .tick       (ser_ui_tick),
      .half_count (trig_half),
      .clk_out_q  (trig_div_out)
   );

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ts_q               <= 1'b0;
         pulse_output_pin_q <= 1'b0;
      end else begin
         ts_q <= timestamp_input;
         if (!trig_en) begin
            pulse_output_pin_q <= 1'b0;
         end else if (trig_mode == `COR_TRIG_TSTAMP) begin
            pulse_output_pin_q <= ts_q;
         end else begin
            pulse_output_pin_q <= trig_div_out;
         end
      end
   end

   // PLL pin override
   assign ovr_en      = pll_ovr_q[`COR_OVR_EN_BIT];
   assign pins        = {clock_config_pin_b, clock_config_pin_a};
   assign first_mode  = ovr_en ? pll_ovr_q[`COR_FIRST_MSB:`COR_FIRST_LSB]
                               : pin_mode(1'b0, pins);
   assign second_mode = ovr_en ? pll_ovr_q[`COR_SECOND_MSB:`COR_SECOND_LSB]
                               : pin_mode(1'b1, pins);
   assign second_eff  = (first_mode == `COR_REF_OFF) ? `COR_REF_OFF : second_mode;

   cor_clk_div u_first_div (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .en         (1'b1),
      .tick       (ref_half_tick),
      .half_count (ref_half(first_mode)),
      .clk_out_q  (first_div_out)
   );

   cor_clk_div u_second_div (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .en         (1'b1),
      .tick       (ref_half_tick),
      .half_count (ref_half(second_eff)),
      .clk_out_q  (second_div_out)
   );

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         first_ref_output_q     <= 1'b0;
         second_ref_output_q    <= 1'b0;
         single_ended_ref_sel_q <= 1'b0;
         pll_enable_q           <= 1'b0;
      end else begin
         first_ref_output_q     <= first_div_out;
         second_ref_output_q    <= second_div_out;
         single_ended_ref_sel_q <= ovr_en ? pll_ovr_q[`COR_SE_SEL_BIT]
                                          : single_ended_ref_pin;
         pll_enable_q           <= ovr_en ? pll_ovr_q[`COR_PLL_EN_BIT]
                                          : pll_enable_pin;
      end
   end
endmodule // cor_regs

// *** testbench/cor_regs_monitor.sv ***
// Port checker for the clock output and PLL override registers
`timescale 1ns/1ns
module cor_regs_monitor (
   clk,
   sys_rst,
   spi_sen_n,
   ser_ui_tick,
   ser_reinit,
   ref_half_tick,
   timestamp_input,
   single_ended_ref_pin,
   pll_enable_pin,
   lane_pre_emphasis_q,
   pulse_output_pin_q,
   first_ref_output_q,
   second_ref_output_q,
   single_ended_ref_sel_q,
   pll_enable_q
);
   input wire        clk, sys_rst, spi_sen_n, ser_ui_tick, ser_reinit, ref_half_tick;
   input wire        timestamp_input, single_ended_ref_pin, pll_enable_pin;
   input wire [31:0] lane_pre_emphasis_q;
   input wire        pulse_output_pin_q, first_ref_output_q, second_ref_output_q;
   input wire        single_ended_ref_sel_q, pll_enable_q;
   reg               frame_seen_q;
   // Pin mode is certain only until software first speaks
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) frame_seen_q <= 1'b0;
      else if (!spi_sen_n) frame_seen_q <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_LANES: assert property (
      lane_pre_emphasis_q[31:4] == {7{lane_pre_emphasis_q[3:0]}}) else $error("lanes differ");
   AST_RST: assert property (
      $fell(sys_rst) |-> !pulse_output_pin_q && !first_ref_output_q && !second_ref_output_q
      && lane_pre_emphasis_q == 32'h0) else $error("bad reset state");
   AST_REINIT: assert property (
      (ser_reinit && !timestamp_input)[*3] |-> !pulse_output_pin_q)
      else $error("trigger runs during restart");
   AST_PULSE: assert property (
      $rose(pulse_output_pin_q) |-> $past(ser_ui_tick) || $past(ser_ui_tick, 2)
      || $past(timestamp_input, 2) || $past(timestamp_input, 3))
      else $error("trigger rose without cause");
   AST_FIRST: assert property (
      $rose(first_ref_output_q) |-> $past(ref_half_tick, 2))
      else $error("first output rose without tick");
   AST_SECOND: assert property (
      $rose(second_ref_output_q) |-> $past(ref_half_tick, 2))
      else $error("second output rose without tick");
   AST_PLL_PIN: assert property (
      !frame_seen_q && !$past(sys_rst) && $stable(pll_enable_pin)
      |-> pll_enable_q == pll_enable_pin) else $error("pll enable ignores pin");
   AST_SE_PIN: assert property (
      !frame_seen_q && !$past(sys_rst) && $stable(single_ended_ref_pin)
      |-> single_ended_ref_sel_q == single_ended_ref_pin) else $error("ref select ignores pin");
   cover property ($rose(pulse_output_pin_q));
   cover property ($rose(second_ref_output_q));
   cover property (frame_seen_q && $rose(first_ref_output_q));
endmodule // cor_regs_monitor

bind cor_regs cor_regs_monitor i_cor_regs_monitor (.clk(clk), .sys_rst(sys_rst),
   .spi_sen_n(spi_sen_n), .ser_ui_tick(ser_ui_tick), .ser_reinit(ser_reinit),
   .ref_half_tick(ref_half_tick), .timestamp_input(timestamp_input),
   .single_ended_ref_pin(single_ended_ref_pin), .pll_enable_pin(pll_enable_pin),
   .lane_pre_emphasis_q(lane_pre_emphasis_q), .pulse_output_pin_q(pulse_output_pin_q),
   .first_ref_output_q(first_ref_output_q), .second_ref_output_q(second_ref_output_q),
   .single_ended_ref_sel_q(single_ended_ref_sel_q), .pll_enable_q(pll_enable_q));

// *** testbench/tb_top.sv ***
// Self-checking bench for the clock output and PLL override registers
`timescale 1ns/1ns
`include "cor_consts.vh"
module tb_top;
   reg         clk, sys_rst, spi_sclk, spi_sdi, spi_sen_n, ser_ui_tick, ser_reinit;
   reg         ref_half_tick, timestamp_input, clock_config_pin_a, clock_config_pin_b;
   reg         single_ended_ref_pin, pll_enable_pin;
   wire        spi_sdo_q, pulse_output_pin_q, first_ref_output_q, second_ref_output_q;
   wire        single_ended_ref_sel_q, pll_enable_q, spi_sdo_oe_n_q;
   wire [31:0] lane_pre_emphasis_q;
   reg  [1:0]  tick_cnt;
   reg  [7:0]  rd;
   reg         oe_rd;
   integer     fails, n_compared;

   cor_regs i_cor_regs (.clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
      .spi_sen_n(spi_sen_n), .spi_sdo_q(spi_sdo_q), .spi_sdo_oe_n_q(spi_sdo_oe_n_q),
      .ser_ui_tick(ser_ui_tick),
      .ser_reinit(ser_reinit), .ref_half_tick(ref_half_tick), .timestamp_input(timestamp_input),
      .clock_config_pin_a(clock_config_pin_a), .clock_config_pin_b(clock_config_pin_b),
      .single_ended_ref_pin(single_ended_ref_pin), .pll_enable_pin(pll_enable_pin),
      .lane_pre_emphasis_q(lane_pre_emphasis_q), .pulse_output_pin_q(pulse_output_pin_q),
      .first_ref_output_q(first_ref_output_q), .second_ref_output_q(second_ref_output_q),
      .single_ended_ref_sel_q(single_ended_ref_sel_q), .pll_enable_q(pll_enable_q));

   always #25 clk = ~clk;
   // One UI every 2 clocks, one reference half period every 4
   always @(posedge clk) begin
      tick_cnt <= tick_cnt + 2'h1;
      ser_ui_tick <= tick_cnt[0];
      ref_half_tick <= (tick_cnt == 2'h3);
   end

   task cmp(input string name, input [31:0] exp, input [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %0s expected %0h seen %0h", name, exp, got);
         end
      end
   endtask

   // Phases of 4 and 3 clocks keep the sampled serial clock well apart
   task spi(input rw, input [14:0] addr, input [7:0] data);
      reg [23:0] frame;
      integer i;
      begin
         frame = {rw, addr, data};
         spi_sen_n <= 1'b0;
         for (i = 23; i >= 0; i = i - 1) begin
            spi_sdi <= frame[i];
            repeat (4) @(posedge clk);
            spi_sclk <= 1'b1;
            if (i < 8) rd[i] = spi_sdo_q;
            if (i == 0) oe_rd = spi_sdo_oe_n_q;
            repeat (3) @(posedge clk);
            spi_sclk <= 1'b0;
         end
         repeat (4) @(posedge clk);
         spi_sen_n <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask

   task rdchk(input string name, input [14:0] addr, input [7:0] exp);
      begin
         spi(1'b1, addr, 8'h00);
         cmp(name, exp, rd);
         cmp("sdo driven", 0, oe_rd);
         cmp("sdo released", 1, spi_sdo_oe_n_q);
      end
   endtask

   function sig(input [1:0] sel);
      sig = sel == 2'h0 ? pulse_output_pin_q : sel == 2'h1 ? first_ref_output_q : second_ref_output_q;
   endfunction

   task wait_lvl(input [1:0] sel, input lvl, inout integer n);
      while (sig(sel) !== lvl && n < 600) begin
         @(posedge clk);
         n = n + 1;
      end
   endtask

   // Clock edges from one rise of the output to the next
   task period(input string name, input [1:0] sel, input integer exp);
      integer n;
      begin
         n = 0;
         wait_lvl(sel, 1'b0, n);
         wait_lvl(sel, 1'b1, n);
         n = 0;
         wait_lvl(sel, 1'b0, n);
         wait_lvl(sel, 1'b1, n);
         cmp(name, exp, n);
      end
   endtask

   task stay_low(input string name, input [1:0] sel, input integer cycles);
      integer i;
      reg seen;
      begin
         seen = 1'b0;
         for (i = 0; i < cycles; i = i + 1) begin
            @(posedge clk);
            seen = seen | sig(sel);
         end
         cmp(name, 0, seen);
      end
   endtask

   task t_pins;
      begin
         period("first pin /1", 2'h1, 8);
         stay_low("second pin off", 2'h2, 64);
         cmp("pll enable pin", 1, pll_enable_q);
         cmp("ref select pin", 1, single_ended_ref_sel_q);
         {clock_config_pin_b, clock_config_pin_a} <= 2'h3;
         period("second pin /2", 2'h2, 16);
      end
   endtask

   task t_regs;
      begin
         rdchk("pre emphasis", `COR_ADDR_PRE_EMPH, 8'h00);
         rdchk("trigger ctrl", `COR_ADDR_TRIG_CTRL, 8'h00);
         rdchk("pll override", `COR_ADDR_PLL_OVR, 8'h00);
         spi(1'b0, 15'h0050, 8'hff);
         cmp("sdo idle on write", 1, oe_rd);
         rdchk("unmapped", 15'h0050, 8'h00);
         spi(1'b0, `COR_ADDR_PRE_EMPH, 8'h0f);
         cmp("lanes", {8{4'hf}}, lane_pre_emphasis_q);
         rdchk("pre emphasis back", `COR_ADDR_PRE_EMPH, 8'h0f);
      end
   endtask

   task t_trig;
      integer m;
      begin
         for (m = 0; m < 8; m = m + 1) begin
            spi(1'b0, `COR_ADDR_TRIG_CTRL, m[7:0]);
            spi(1'b0, `COR_ADDR_TRIG_CTRL, 8'h80 | m[7:0]);
            if (m < 3) period("ui clock", 2'h0, 32 << m);
            else if (m == 3) begin
               timestamp_input <= 1'b1;
               repeat (4) @(posedge clk);
               cmp("stamp high", 1, pulse_output_pin_q);
               timestamp_input <= 1'b0;
               repeat (4) @(posedge clk);
               cmp("stamp low", 0, pulse_output_pin_q);
            end else stay_low("reserved mode", 2'h0, 150);
            spi(1'b0, `COR_ADDR_TRIG_CTRL, m[7:0]);
            stay_low("disabled", 2'h0, 100);
         end
         spi(1'b0, `COR_ADDR_TRIG_CTRL, 8'h00);
         spi(1'b0, `COR_ADDR_TRIG_CTRL, 8'h80);
         ser_reinit <= 1'b1;
         repeat (2) @(posedge clk);
         stay_low("restart", 2'h0, 80);
         ser_reinit <= 1'b0;
         period("after restart", 2'h0, 32);
      end
   endtask

   task t_ovr;
      integer f;
      begin
         {clock_config_pin_b, clock_config_pin_a, single_ended_ref_pin, pll_enable_pin} <= 4'h0;
         for (f = 1; f < 4; f = f + 1) begin
            spi(1'b0, `COR_ADDR_PLL_OVR, 8'h83 | f[7:0] << 2 | f[7:0] << 4);
            period("first override", 2'h1, 4 << f);
            period("second override", 2'h2, 4 << f);
            cmp("pll enable", 1, pll_enable_q);
            cmp("ref select", 1, single_ended_ref_sel_q);
         end
         // Pins high so the override values are told apart from them
         {single_ended_ref_pin, pll_enable_pin} <= 2'h3;
         spi(1'b0, `COR_ADDR_PLL_OVR, 8'h90);
         stay_low("second alone", 2'h2, 64);
         cmp("pll disable", 0, pll_enable_q);
         cmp("ref deselect", 0, single_ended_ref_sel_q);
         // First output on by pins, so a leaking field would start the second
         {clock_config_pin_b, clock_config_pin_a} <= 2'h1;
         spi(1'b0, `COR_ADDR_PLL_OVR, 8'h30);
         stay_low("field ignored", 2'h2, 64);
         period("first by pins", 2'h1, 8);
         cmp("pll enable by pin", 1, pll_enable_q);
         cmp("ref select by pin", 1, single_ended_ref_sel_q);
      end
   endtask

   // Reset in mid-run must clear every register that was programmed
   task t_reset;
      begin
         sys_rst <= 1'b1;
         repeat (4) @(posedge clk);
         sys_rst <= 1'b0;
         repeat (2) @(posedge clk);
         cmp("lanes after reset", 0, lane_pre_emphasis_q);
         stay_low("trigger after reset", 2'h0, 80);
         rdchk("pre emphasis again", `COR_ADDR_PRE_EMPH, 8'h00);
         rdchk("trigger ctrl again", `COR_ADDR_TRIG_CTRL, 8'h00);
         rdchk("pll override again", `COR_ADDR_PLL_OVR, 8'h00);
         cmp("pin mode again", 1, pll_enable_q);
      end
   endtask

   task test_done;
      begin
         $display("compared %0d failed %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      fails = fails + 1;
      test_done;
   end

   initial begin
      {clk, spi_sclk, spi_sdi, ser_ui_tick, ser_reinit, ref_half_tick, timestamp_input} = 7'h00;
      {clock_config_pin_b, clock_config_pin_a, single_ended_ref_pin, pll_enable_pin} = 4'h7;
      {sys_rst, spi_sen_n, tick_cnt, fails, n_compared} = {2'h3, 2'h0, 64'h0};
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_pins;
      t_regs;
      t_trig;
      t_ovr;
      t_reset;
      test_done;
   end
endmodule // tb_top
